//--- rtl/supply_gain_manager.sv
// supply-driven audio gain and mute manager
// assumes the voltage monitor delivers synchronous level flags and that
// the audio path applies the attenuation and mute it is handed
//
// Behaviour
// - deep mode: mute when supply falls below low
// - deep mode: hold mute until hardware reset level
// - deep reset: load memory A, resume above upper
// - instantaneous dip with average good: one step
// - ignore instantaneous dips during stabilization interval
// - second dip adds step, restarts stabilization
// - at most two instantaneous steps
// - evaluate instantaneous supply over consecutive periods
// - whole period above upper removes instantaneous steps
// - two steps, period above mid: back to one
// - average low: one step per interval down
// - maximum average steps: stop and mute
// - average above upper: unmute before restoring gain
// - recovery: one step up per interval
// - average between levels: hold average steps
// - counts independent, gain reflects both
`timescale 1ns/1ps
`default_nettype none

module supply_gain_manager #(
    parameter int unsigned TICK_DIV   = supply_gain_pkg::TICK_DIV,
    parameter int unsigned INST_TICKS = supply_gain_pkg::INST_TICKS,
    parameter int unsigned AVG_TICKS  = supply_gain_pkg::AVG_TICKS
) (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    // configuration
    input  wire logic                     advancedMode,
    // supply monitor
    input  wire supply_gain_pkg::supply_t supply,
    // audio path
    output logic [7:0]                    attenDb,
    output logic                          audioMute,
    output logic                          loadMemoryA,
    output logic [1:0]                    instSteps,
    output logic [4:0]                    avgSteps
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstSync1;
    logic rstSync2;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    wire logic resetN = rstSync2;

    // ------------------------------------------------------------
    // tick divider
    // ------------------------------------------------------------
    logic [31:0] divCnt;
    logic [31:0] next_divCnt;
    logic        tick;
    always_comb begin
        tick        = (divCnt == TICK_DIV - 1);
        next_divCnt = tick ? 32'h0 : divCnt + 32'h1;
    end
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) divCnt <= 32'h0;
        else divCnt <= next_divCnt;
    end

    // ------------------------------------------------------------
    // deep reset mode
    // ------------------------------------------------------------
    supply_gain_pkg::deep_state_t deepState;
    supply_gain_pkg::deep_state_t next_deepState;
    logic                         next_loadMemoryA;
    always_comb begin
        next_deepState   = deepState;
        next_loadMemoryA = 1'b0;
        unique case (deepState)
            supply_gain_pkg::DEEP_RUN: begin
                if (!supply.inst.aboveLow) next_deepState = supply_gain_pkg::DEEP_MUTE;
            end
            supply_gain_pkg::DEEP_MUTE: begin
                if (supply.belowHwReset) next_deepState = supply_gain_pkg::DEEP_WAIT;
            end
            // reload memory A, resume above upper
            supply_gain_pkg::DEEP_WAIT: begin
                if (!supply.belowHwReset && supply.inst.aboveHigh) begin
                    next_deepState   = supply_gain_pkg::DEEP_RUN;
                    next_loadMemoryA = 1'b1;
                end
            end
        endcase
        if (advancedMode) next_deepState = supply_gain_pkg::DEEP_RUN;
    end
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            deepState   <= supply_gain_pkg::DEEP_RUN;
            loadMemoryA <= 1'b0;
        end else begin
            deepState   <= next_deepState;
            loadMemoryA <= next_loadMemoryA;
        end
    end

    // ------------------------------------------------------------
    // instantaneous reductions
    // ------------------------------------------------------------
    logic [31:0] instTimer;
    logic [31:0] next_instTimer;
    logic        instHold;        // stabilization interval running
    logic        next_instHold;
    logic        perHigh;         // period stayed above upper so far
    logic        perMid;
    logic        next_perHigh;
    logic        next_perMid;
    logic [1:0]  next_instSteps;
    logic        periodEnd;
    always_comb begin
        next_instTimer = instTimer;
        next_instHold  = instHold;
        next_perHigh   = perHigh & supply.inst.aboveHigh;
        next_perMid    = perMid & supply.inst.aboveMid;
        next_instSteps = instSteps;
        periodEnd      = tick && (instTimer == INST_TICKS - 1);
        if (tick) next_instTimer = instTimer + 32'h1;
        if (!advancedMode) begin
            next_instSteps = 2'h0;
            next_instTimer = 32'h0;
            next_instHold  = 1'b0;
        end else if (instSteps == 2'h0) begin
            next_instTimer = 32'h0;
            next_perHigh   = 1'b1;
            next_perMid    = 1'b1;
            if (!supply.inst.aboveLow && supply.avg.aboveLow) begin
                next_instSteps = 2'h1;
                next_instHold  = 1'b1;
            end
        end else begin
            if (!instHold && !supply.inst.aboveLow && instSteps < supply_gain_pkg::INST_MAX_STEPS) begin
                next_instSteps = instSteps + 2'h1;
                next_instHold  = 1'b1;
                next_instTimer = 32'h0;
                next_perHigh   = 1'b1;
                next_perMid    = 1'b1;
            end else if (periodEnd) begin
                next_instTimer = 32'h0;
                next_instHold  = 1'b0;
                next_perHigh   = 1'b1;
                next_perMid    = 1'b1;
                if (perHigh && supply.inst.aboveHigh) next_instSteps = 2'h0;
                else if (instSteps == 2'h2 && perMid && supply.inst.aboveMid) next_instSteps = 2'h1;
            end
        end
    end
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            instTimer <= 32'h0;
            instHold  <= 1'b0;
            perHigh   <= 1'b1;
            perMid    <= 1'b1;
            instSteps <= 2'h0;
        end else begin
            instTimer <= next_instTimer;
            instHold  <= next_instHold;
            perHigh   <= next_perHigh;
            perMid    <= next_perMid;
            instSteps <= next_instSteps;
        end
    end

    // ------------------------------------------------------------
    // average reductions
    // ------------------------------------------------------------
    logic [31:0] avgTimer;
    logic [31:0] next_avgTimer;
    logic [4:0]  next_avgSteps;
    logic        avgMute;
    logic        next_avgMute;
    logic        avgStep;
    always_comb begin
        next_avgTimer = avgTimer;
        next_avgSteps = avgSteps;
        next_avgMute  = avgMute;
        avgStep       = tick && (avgTimer == AVG_TICKS - 1);
        if (!advancedMode) begin
            next_avgTimer = 32'h0;
            next_avgSteps = 5'h0;
            next_avgMute  = 1'b0;
        end else if (!supply.avg.aboveLow) begin
            if (tick) next_avgTimer = avgStep ? 32'h0 : avgTimer + 32'h1;
            if (avgStep && avgSteps < supply_gain_pkg::AVG_MAX_STEPS) next_avgSteps = avgSteps + 5'h1;
            if (next_avgSteps == supply_gain_pkg::AVG_MAX_STEPS) next_avgMute = 1'b1;
        end else if (supply.avg.aboveHigh) begin
            if (avgMute) begin
                next_avgMute  = 1'b0;
                next_avgTimer = 32'h0;
            end else if (avgSteps != 5'h0) begin
                if (tick) next_avgTimer = avgStep ? 32'h0 : avgTimer + 32'h1;
                if (avgStep) next_avgSteps = avgSteps - 5'h1;
            end else begin
                next_avgTimer = 32'h0;
            end
        end else begin
            next_avgTimer = 32'h0;
        end
    end
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            avgTimer <= 32'h0;
            avgSteps <= 5'h0;
            avgMute  <= 1'b0;
        end else begin
            avgTimer <= next_avgTimer;
            avgSteps <= next_avgSteps;
            avgMute  <= next_avgMute;
        end
    end

    // ------------------------------------------------------------
    // outputs to the audio path
    // ------------------------------------------------------------
    logic [7:0] next_attenDb;
    logic       next_audioMute;
    always_comb begin
        next_attenDb   = 8'(next_instSteps * supply_gain_pkg::INST_STEP_DB) + 8'(next_avgSteps);
        next_audioMute = advancedMode ? next_avgMute : (next_deepState != supply_gain_pkg::DEEP_RUN);
    end
    always_ff @(posedge mclk or negedge resetN) begin
        if (!resetN) begin
            attenDb   <= supply_gain_pkg::ATTEN_RESET;
            audioMute <= 1'b0;
        end else begin
            attenDb   <= next_attenDb;
            audioMute <= next_audioMute;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_inst_cap: assert property (@(posedge mclk) disable iff (!resetN) instSteps <= 2'h2)
        else $error("too many instantaneous steps");
    chk_first_dip: assert property (@(posedge mclk) disable iff (!resetN)
        advancedMode && instSteps == 2'h0 && !supply.inst.aboveLow && supply.avg.aboveLow
        |=> instSteps == 2'h1)
        else $error("dip did not reduce gain");
    chk_hold_dip: assert property (@(posedge mclk) disable iff (!resetN)
        advancedMode && instHold && !periodEnd && instSteps == 2'h1 |=> instSteps != 2'h2)
        else $error("dip acted during stabilization");
    chk_avg_cap: assert property (@(posedge mclk) disable iff (!resetN) avgSteps <= 5'h12)
        else $error("average steps beyond maximum");
    chk_avg_hold: assert property (@(posedge mclk) disable iff (!resetN)
        advancedMode && supply.avg.aboveLow && !supply.avg.aboveHigh |=> $stable(avgSteps))
        else $error("average steps moved in hold band");
    chk_unmute_first: assert property (@(posedge mclk) disable iff (!resetN)
        advancedMode && avgMute && supply.avg.aboveHigh |=> !avgMute && $stable(avgSteps))
        else $error("gain restored before unmute");
    chk_deep_mute: assert property (@(posedge mclk) disable iff (!resetN)
        !advancedMode && deepState == supply_gain_pkg::DEEP_RUN && !supply.inst.aboveLow |=> audioMute)
        else $error("deep mode did not mute");
    chk_deep_resume: assert property (@(posedge mclk) disable iff (!resetN)
        !advancedMode && deepState == supply_gain_pkg::DEEP_WAIT && !supply.belowHwReset && supply.inst.aboveHigh
        |=> loadMemoryA && !audioMute)
        else $error("deep mode did not resume with memory A");
    chk_mem_pulse: assert property (@(posedge mclk) disable iff (!resetN) loadMemoryA |=> !loadMemoryA)
        else $error("memory A load longer than one cycle");
    chk_avg_mute: assert property (@(posedge mclk) disable iff (!resetN)
        advancedMode && avgSteps == 5'h12 && !supply.avg.aboveLow |=> audioMute)
        else $error("no mute at maximum average steps");
    chk_deep_hold: assert property (@(posedge mclk) disable iff (!resetN)
        !advancedMode && deepState == supply_gain_pkg::DEEP_MUTE && !supply.belowHwReset
        |=> deepState == supply_gain_pkg::DEEP_MUTE)
        else $error("deep mute released early");
    // attenuation and step counts are registered from the same next values
    chk_gain_sum: assert property (@(posedge mclk) disable iff (!resetN)
        attenDb == 8'(instSteps * 3'h3) + 8'(avgSteps))
        else $error("attenuation does not match steps");

endmodule : supply_gain_manager
`default_nettype wire

//--- rtl/supply_gain_pkg.sv
// shared constants and types for the supply-driven gain manager
// assumes a single 50 MHz clock and synchronous comparator flags
package supply_gain_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 50_000_000;
    localparam int unsigned TICK_HZ        = 1_000;      // timer tick rate
    localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
    localparam int unsigned INST_PERIOD_S  = 30;         // instantaneous monitoring period
    localparam int unsigned AVG_STEP_S     = 10;         // average step interval
    localparam int unsigned INST_TICKS     = INST_PERIOD_S * TICK_HZ;
    localparam int unsigned AVG_TICKS      = AVG_STEP_S * TICK_HZ;

    // ------------------------------------------------------------
    // step counts and gain sizes
    // ------------------------------------------------------------
    localparam logic [1:0] INST_MAX_STEPS  = 2'h2;
    localparam logic [4:0] AVG_MAX_STEPS   = 5'h12;      // eighteen steps
    localparam logic [2:0] INST_STEP_DB    = 3'h3;
    localparam logic [7:0] ATTEN_RESET     = 8'h00;

    // ------------------------------------------------------------
    // comparator flag bundle: 1 means supply above that level
    // ------------------------------------------------------------
    typedef struct packed {
        logic aboveLow;   // above 0.95 V
        logic aboveMid;   // above 1.0 V
        logic aboveHigh;  // above 1.1 V
    } levels_t;

    typedef struct packed {
        levels_t inst;
        levels_t avg;
        logic    belowHwReset; // below 0.6 V
    } supply_t;

    // deep reset mode states
    typedef enum logic [2:0] {
        DEEP_RUN  = 3'h1,
        DEEP_MUTE = 3'h2,
        DEEP_WAIT = 3'h4
    } deep_state_t;

endpackage : supply_gain_pkg

//--- tb/supply_monitor_model.sv
// behavioural battery monitor: turns millivolt levels into level flags
// assumes the bench changes the levels just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none

module supply_monitor_model (
    // supply levels in millivolts
    input  wire logic [15:0]              instMv,
    input  wire logic [15:0]              avgMv,
    // comparator flags
    output wire supply_gain_pkg::supply_t supply
);
    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    // level flags
    // flags move only when the bench moves the levels, so they stay synchronous
    assign supply = supply_gain_pkg::supply_t'({instMv > 16'h03b6, instMv > 16'h03e8, instMv > 16'h044c,
                                                avgMv > 16'h03b6, avgMv > 16'h03e8, avgMv > 16'h044c,
                                                instMv < 16'h0258});
endmodule : supply_monitor_model

`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the supply-driven gain manager
// assumes shortened timers: tick every 4 cycles, period 5 ticks, step 3 ticks
`timescale 1ns/1ps
`default_nettype none

module tb;
    // levels in millivolts
    localparam logic [15:0] V_HWRST = 16'h01f4;
    localparam logic [15:0] V_LOW   = 16'h0384;
    localparam logic [15:0] V_SAG   = 16'h03ca;
    localparam logic [15:0] V_MID   = 16'h041a;
    localparam logic [15:0] V_HIGH  = 16'h04b0;

    logic                     mclk;
    logic                     rstn;
    logic                     advancedMode;
    logic [15:0]              instMv;
    logic [15:0]              avgMv;
    supply_gain_pkg::supply_t supply;
    logic [7:0]               attenDb;
    logic                     audioMute;
    logic                     loadMemoryA;
    logic [1:0]               instSteps;
    logic [4:0]               avgSteps;
    int                       failCount = 0;
    int                       numChecks = 0;

    supply_monitor_model monitor (.instMv(instMv), .avgMv(avgMv), .supply(supply));

    supply_gain_manager #(.TICK_DIV(4), .INST_TICKS(5), .AVG_TICKS(3)) uut (
        .mclk(mclk), .rstn(rstn), .advancedMode(advancedMode), .supply(supply), .attenDb(attenDb),
        .audioMute(audioMute), .loadMemoryA(loadMemoryA), .instSteps(instSteps), .avgSteps(avgSteps));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // clock generator
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic conclude;
        $display("checks=%0d mismatches=%0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [7:0] pick(input int sel);
        case (sel)
            0: return {6'h00, instSteps};
            1: return {3'h0, avgSteps};
            2: return {7'h00, audioMute};
            default: return {7'h00, loadMemoryA};
        endcase
    endfunction : pick

    // waits a bounded number of cycles for an output to reach a value
    task automatic waitVal(input int sel, input logic [7:0] val, input int limit);
        for (int i = 0; i < limit; i++) begin
            @(negedge mclk);
            if (pick(sel) === val) break;
        end
        check(pick(sel), val);
    endtask : waitVal

    // reset for 20 cycles, outputs must read zero, then 3 cycles of settling
    task automatic doReset(input logic adv);
        @(negedge mclk);
        rstn = 1'b0;
        advancedMode = adv;
        instMv = V_HIGH;
        avgMv = V_HIGH;
        repeat (20) @(negedge mclk);
        check(attenDb, 8'h00);
        check({6'h00, audioMute, loadMemoryA}, 8'h00);
        check({1'b0, instSteps, avgSteps}, 8'h00);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
    endtask : doReset

    // one-cycle instantaneous dip, checked at the next falling edge
    task automatic pulseDip;
        logic [15:0] prev;
        prev = instMv;
        instMv = V_LOW;
        @(negedge mclk);
        instMv = prev;
    endtask : pulseDip

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testDeep;
        doReset(1'b0);
        check(pick(2), 8'h00);
        instMv = V_LOW;
        @(negedge mclk);
        check(pick(2), 8'h01);
        instMv = V_HIGH;
        repeat (10) @(negedge mclk);
        check(pick(2), 8'h01);
        instMv = V_HWRST;
        repeat (3) @(negedge mclk);
        instMv = V_HIGH;
        waitVal(3, 8'h01, 3);
        check(pick(2), 8'h00);
        @(negedge mclk);
        check(pick(3), 8'h00);
        $display("deep mode test done");
    endtask : testDeep

    task automatic testInst;
        doReset(1'b1);
        pulseDip();
        check(pick(0), 8'h01);
        check(attenDb, 8'h03);
        pulseDip();
        check(pick(0), 8'h01);
        instMv = V_SAG;
        repeat (30) @(negedge mclk);
        pulseDip();
        check(pick(0), 8'h02);
        check(attenDb, 8'h06);
        repeat (30) @(negedge mclk);
        pulseDip();
        check(pick(0), 8'h02);
        instMv = V_MID;
        waitVal(0, 8'h01, 60);
        instMv = V_HIGH;
        waitVal(0, 8'h00, 60);
        check(attenDb, 8'h00);
        $display("instantaneous test done");
    endtask : testInst

    task automatic testAvg;
        doReset(1'b1);
        avgMv = V_LOW;
        waitVal(1, 8'h01, 20);
        check(attenDb, 8'h01);
        waitVal(1, 8'h12, 320);
        check(pick(2), 8'h01);
        repeat (30) @(negedge mclk);
        check(pick(1), 8'h12);
        avgMv = V_MID;
        repeat (40) @(negedge mclk);
        check(pick(1), 8'h12);
        pulseDip();
        check(attenDb, 8'h15);
        avgMv = V_HIGH;
        waitVal(2, 8'h00, 3);
        check(pick(1), 8'h12);
        waitVal(1, 8'h11, 20);
        waitVal(1, 8'h00, 300);
        $display("average test done");
    endtask : testAvg

    task automatic testReset;
        doReset(1'b1);
        avgMv = V_LOW;
        pulseDip();
        check(pick(0), 8'h00);
        waitVal(1, 8'h02, 40);
        doReset(1'b1);
        $display("reset test done");
    endtask : testReset

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        advancedMode = 1'b0;
        instMv = V_HIGH;
        avgMv = V_HIGH;
        testDeep();
        testInst();
        testAvg();
        testReset();
        conclude();
    end

    // cuts a hang short, far beyond the expected run of some 800 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        failCount++;
        $display("watchdog expired");
        conclude();
    end
endmodule : tb

`default_nettype wire
